// file: hw/egc_pkg.sv
// Package for the exposure gain configuration register bank
package egc_pkg;

  // Register offsets on the two-wire control port
  localparam logic [7:0] EGC_OFS_GAIN_A    = 8'h10;
  localparam logic [7:0] EGC_OFS_BIAS_PWR  = 8'h13;
  localparam logic [7:0] EGC_OFS_GAIN_B    = 8'h21;
  localparam logic [7:0] EGC_OFS_GAIN_MODE = 8'h22;

  // Reset values
  localparam logic [5:0] EGC_RST_GAIN      = 6'h0e;
  localparam logic [6:0] EGC_RST_BIAS      = 7'h00;
  localparam logic [2:0] EGC_RST_MODE      = 3'h0;

  // Field widths and positions
  localparam int         EGC_GAIN_W        = 6;
  localparam int         EGC_BIAS_W        = 7;
  localparam int         EGC_MODE_W        = 3;
  localparam int         EGC_FCP_BIT       = 0;
  localparam int         EGC_WBM_BIT       = 2;
  localparam int         EGC_EGM_LSB       = 0;
  localparam int         EGC_EGM_MSB       = 1;

  // Gain figures in units of 0.00001
  localparam int         EGC_GVAL_W        = 20;
  localparam logic [19:0] EGC_RAW_BASE     = 20'h10fb8;
  localparam logic [19:0] EGC_RAW_FINE     = 20'h0087e;
  localparam logic [19:0] EGC_RAW_KNEE_VAL = 20'h21f5c;
  localparam logic [5:0]  EGC_RAW_KNEE     = 6'h20;
  localparam logic [19:0] EGC_LIN_BASE     = 20'h10fb8;
  localparam logic [19:0] EGC_COARSE_STEP  = 20'h010f4;
  localparam logic [19:0] EGC_LIN2_BASE    = 20'h0bd10;
  localparam logic [19:0] EGC_LIN2_STEP    = 20'h02ee0;

  // Serial port bit count per byte
  localparam logic [3:0] EGC_BYTE_BITS     = 4'h8;

  typedef enum logic [1:0] {
    EGC_EXP_RAW,
    EGC_EXP_LINEAR,
    EGC_EXP_LINEAR2
  } egc_exp_mode_e;

  typedef enum logic {
    EGC_WB_RAW,
    EGC_WB_LINEAR
  } egc_wb_mode_e;

  typedef struct packed {
    logic [5:0]    gain_word_first;
    logic [5:0]    gain_word_second;
    logic          second_used;
    logic [19:0]   gain_first_val;
    logic [19:0]   gain_second_val;
    egc_exp_mode_e exp_mode;
    egc_wb_mode_e  wb_mode;
  } egc_gain_cfg_s;

  typedef struct packed {
    logic [6:0] bias_bits;
    logic       frc_half_current;
  } egc_bias_cfg_s;

endpackage

// file: hw/egc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module egc_pin_sync
  import egc_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  output logic      o_level
);

  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       level_reg;
  logic       level_next;

  // Stage one feeds only stage two; a change counts once two and three agree
  always_comb begin
    sync_next  = {sync_reg[1:0], i_pin};
    level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_reg  <= {3{RESET_LEVEL}};
      level_reg <= RESET_LEVEL;
    end else begin
      sync_reg  <= sync_next;
      level_reg <= level_next;
    end
  end

  assign o_level = level_reg;

endmodule

// file: hw/egc_regs.sv
// Exposure gain configuration registers behind a two-wire serial port
// Notes on behaviour
// [RULE1] Bias bit 0 picks full current for the frame rate clamp, 1 half.
// [RULE2] Bias settings take effect only while the bias enable input is set.
// [RULE3] Two 6-bit exposure gain words apply to every pixel output.
// [RULE4] Raw and linear exposure modes use both gain words.
// [RULE5] The second linear mode uses only the first word, ignoring the other.
// [RULE6] Two white-balance modes and three exposure modes are offered.
// [RULE7] Raw mode maps codes over 32 fine steps then 32 coarse steps; the code uses fine steps for codes 0 to 32 and coarse steps for 33 to 63.
// [RULE8] Linear mode maps codes over uniform coarse steps.
// [RULE9] Second linear mode maps the first word over 64 steps of about 0.12.
// [RULE10] One mode bit selects white balance, a 2-bit field the exposure mode.
// [RULE11] Unused upper register bits ignore writes and read as zero.
`timescale 1ns/1ps
module egc_regs
  import egc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input  wire logic    i_core_clk,
  input  wire logic    i_resetn,
  input  wire logic    i_scl,
  input  wire logic    i_sda,
  output logic         o_sda,
  output logic         o_sda_oe_n,
  input  wire logic    i_bias_gen_en,
  output egc_gain_cfg_s o_gain_cfg,
  output egc_bias_cfg_s o_bias_cfg
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_SUB,
    ST_SUB_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } egc_state_e;

  // Exposure mode field decode; 1x both mean second linear mode
  function automatic egc_exp_mode_e exp_mode_of(input logic [1:0] f);
    if (f[1]) begin
      exp_mode_of = EGC_EXP_LINEAR2; // [RULE6] [RULE10]
    end else if (f[0]) begin
      exp_mode_of = EGC_EXP_LINEAR;
    end else begin
      exp_mode_of = EGC_EXP_RAW;
    end
  endfunction

  // Gain figure in units of 0.00001 for one code in one mode
  function automatic logic [19:0] gain_val(input egc_exp_mode_e m,
                                           input logic [5:0]    g);
    logic [19:0] c;
    c = {14'h0, g};
    case (m)
      EGC_EXP_RAW: begin
        if (g <= EGC_RAW_KNEE) begin
          gain_val = 20'(EGC_RAW_BASE + EGC_RAW_FINE * c); // [RULE7]
        end else begin
          gain_val = 20'(EGC_RAW_KNEE_VAL + EGC_COARSE_STEP
                         * (c - {14'h0, EGC_RAW_KNEE})); // [RULE7]
        end
      end
      EGC_EXP_LINEAR: gain_val = 20'(EGC_LIN_BASE + EGC_COARSE_STEP * c); // [RULE8]
      EGC_EXP_LINEAR2: gain_val = 20'(EGC_LIN2_BASE + EGC_LIN2_STEP * c); // [RULE9]
      default: gain_val = 20'h0;
    endcase
  endfunction

  logic             scl;
  logic             sda;
  logic             scl_prev_reg;
  logic             sda_prev_reg;

  egc_pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_pin      (i_scl),
    .o_level    (scl)
  );

  egc_pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_pin      (i_sda),
    .o_level    (sda)
  );

  logic             scl_rise;
  logic             scl_fall;
  logic             bus_start;
  logic             bus_stop;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl;
      sda_prev_reg <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_prev_reg;
  assign scl_fall  = ~scl & scl_prev_reg;
  assign bus_start = scl & scl_prev_reg & sda_prev_reg & ~sda;
  assign bus_stop  = scl & scl_prev_reg & ~sda_prev_reg & sda;

  egc_state_e       state_reg;
  egc_state_e       state_next;
  logic [3:0]       cnt_reg;
  logic [3:0]       cnt_next;
  logic [7:0]       shift_reg;
  logic [7:0]       shift_next;
  logic [7:0]       tx_reg;
  logic [7:0]       tx_next;
  logic [7:0]       ptr_reg;
  logic [7:0]       ptr_next;
  logic             rd_reg;
  logic             rd_next;
  logic             drive_reg;
  logic             drive_next;
  logic             nack_reg;
  logic             nack_next;
  logic [5:0]       gain_a_reg;
  logic [5:0]       gain_a_next;
  logic [5:0]       gain_b_reg;
  logic [5:0]       gain_b_next;
  logic [6:0]       bias_reg;
  logic [6:0]       bias_next;
  logic [2:0]       mode_reg;
  logic [2:0]       mode_next;

  // Read decode; unused bits and unmapped offsets return zero
  function automatic logic [7:0] reg_read(input logic [7:0] a,
                                          input logic [5:0] ga,
                                          input logic [6:0] bs,
                                          input logic [5:0] gb,
                                          input logic [2:0] md);
    case (a)
      EGC_OFS_GAIN_A:    reg_read = {2'h0, ga}; // [RULE11]
      EGC_OFS_BIAS_PWR:  reg_read = {1'h0, bs};
      EGC_OFS_GAIN_B:    reg_read = {2'h0, gb}; // [RULE11]
      EGC_OFS_GAIN_MODE: reg_read = {5'h0, md}; // [RULE11]
      default:           reg_read = 8'h00;
    endcase
  endfunction

  // Byte at the pointer, shared by the first and every following read byte
  logic [7:0]       rd_byte;
  assign rd_byte = reg_read(ptr_reg, gain_a_reg, bias_reg, gain_b_reg,
                            mode_reg);

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    shift_next  = shift_reg;
    tx_next     = tx_reg;
    ptr_next    = ptr_reg;
    rd_next     = rd_reg;
    drive_next  = drive_reg;
    nack_next   = nack_reg;
    gain_a_next = gain_a_reg;
    gain_b_next = gain_b_reg;
    bias_next   = bias_reg;
    mode_next   = mode_reg;
    if (bus_stop) begin
      state_next = ST_IDLE;
      drive_next = 1'b0;
    end else if (bus_start) begin
      state_next = ST_ADDR;
      cnt_next   = 4'h0;
      drive_next = 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        ST_ADDR, ST_SUB, ST_WDATA: begin
          shift_next = {shift_reg[6:0], sda};
          cnt_next   = cnt_reg + 4'h1;
        end
        ST_RDATA:     cnt_next  = cnt_reg + 4'h1;
        ST_RDATA_ACK: nack_next = sda;
        default:      cnt_next  = cnt_reg;
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        ST_ADDR: begin
          if (cnt_reg == EGC_BYTE_BITS) begin
            if (shift_reg[7:1] == DEV_ADDR) begin
              rd_next    = shift_reg[0];
              drive_next = 1'b1;
              state_next = ST_ADDR_ACK;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_SUB: begin
          if (cnt_reg == EGC_BYTE_BITS) begin
            ptr_next   = shift_reg;
            drive_next = 1'b1;
            state_next = ST_SUB_ACK;
          end
        end
        ST_WDATA: begin
          if (cnt_reg == EGC_BYTE_BITS) begin
            case (ptr_reg)
              EGC_OFS_GAIN_A:    gain_a_next = shift_reg[5:0]; // [RULE3] [RULE11]
              EGC_OFS_GAIN_B:    gain_b_next = shift_reg[5:0]; // [RULE3] [RULE11]
              EGC_OFS_BIAS_PWR:  bias_next   = shift_reg[6:0];
              EGC_OFS_GAIN_MODE: mode_next   = shift_reg[2:0]; // [RULE11]
              default:           mode_next   = mode_reg;
            endcase
            ptr_next   = ptr_reg + 8'h01;
            drive_next = 1'b1;
            state_next = ST_WDATA_ACK;
          end
        end
        ST_ADDR_ACK: begin
          cnt_next = 4'h0;
          if (rd_reg) begin
            tx_next    = rd_byte << 1;
            drive_next = ~rd_byte[7];
            state_next = ST_RDATA;
          end else begin
            drive_next = 1'b0;
            state_next = ST_SUB;
          end
        end
        ST_SUB_ACK, ST_WDATA_ACK: begin
          cnt_next   = 4'h0;
          drive_next = 1'b0;
          state_next = ST_WDATA;
        end
        ST_RDATA: begin
          if (cnt_reg == EGC_BYTE_BITS) begin
            drive_next = 1'b0;
            ptr_next   = ptr_reg + 8'h01;
            state_next = ST_RDATA_ACK;
          end else begin
            drive_next = ~tx_reg[7];
            tx_next    = tx_reg << 1;
          end
        end
        ST_RDATA_ACK: begin
          cnt_next = 4'h0;
          if (nack_reg) begin
            drive_next = 1'b0;
            state_next = ST_IDLE;
          end else begin
            tx_next    = rd_byte << 1;
            drive_next = ~rd_byte[7];
            state_next = ST_RDATA;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 4'h0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      ptr_reg    <= 8'h00;
      rd_reg     <= 1'b0;
      drive_reg  <= 1'b0;
      nack_reg   <= 1'b0;
      gain_a_reg <= EGC_RST_GAIN;
      gain_b_reg <= EGC_RST_GAIN;
      bias_reg   <= EGC_RST_BIAS;
      mode_reg   <= EGC_RST_MODE;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      tx_reg     <= tx_next;
      ptr_reg    <= ptr_next;
      rd_reg     <= rd_next;
      drive_reg  <= drive_next;
      nack_reg   <= nack_next;
      gain_a_reg <= gain_a_next;
      gain_b_reg <= gain_b_next;
      bias_reg   <= bias_next;
      mode_reg   <= mode_next;
    end
  end

  // Open drain: the pin only ever pulls low
  assign o_sda      = 1'b0;
  assign o_sda_oe_n = ~drive_reg;

  // Gain outputs derived from registers, so they stay stable between writes
  egc_gain_cfg_s gain_cfg_reg;
  egc_gain_cfg_s gain_cfg_next;
  egc_bias_cfg_s bias_cfg_reg;
  egc_bias_cfg_s bias_cfg_next;
  egc_exp_mode_e exp_mode;

  always_comb begin
    exp_mode = exp_mode_of(mode_reg[EGC_EGM_MSB:EGC_EGM_LSB]); // [RULE10]
    gain_cfg_next.exp_mode         = exp_mode;
    gain_cfg_next.wb_mode          = egc_wb_mode_e'(mode_reg[EGC_WBM_BIT]); // [RULE6]
    gain_cfg_next.gain_word_first  = gain_a_reg; // [RULE3]
    gain_cfg_next.gain_first_val   = gain_val(exp_mode, gain_a_reg);
    gain_cfg_next.second_used      = (exp_mode != EGC_EXP_LINEAR2); // [RULE4] [RULE5]
    if (exp_mode == EGC_EXP_LINEAR2) begin
      gain_cfg_next.gain_word_second = 6'h00; // [RULE5]
      gain_cfg_next.gain_second_val  = 20'h0; // [RULE5]
    end else begin
      gain_cfg_next.gain_word_second = gain_b_reg; // [RULE4]
      gain_cfg_next.gain_second_val  = gain_val(exp_mode, gain_b_reg); // [RULE4]
    end
    // Disabled bias generator falls back to full current everywhere
    bias_cfg_next.bias_bits        = i_bias_gen_en ? bias_reg : 7'h00; // [RULE2]
    bias_cfg_next.frc_half_current = i_bias_gen_en
                                     & bias_reg[EGC_FCP_BIT]; // [RULE1] [RULE2]
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gain_cfg_reg <= '0;
      bias_cfg_reg <= '0;
    end else begin
      gain_cfg_reg <= gain_cfg_next;
      bias_cfg_reg <= bias_cfg_next;
    end
  end

  assign o_gain_cfg = gain_cfg_reg;
  assign o_bias_cfg = bias_cfg_reg;

endmodule

// file: tb/egc_regs_props.sv
// Concurrent checks on the gain configuration register bank ports
`timescale 1ns/1ps
module egc_regs_props
  import egc_pkg::*;
(
  input wire logic          i_core_clk,
  input wire logic          i_resetn,
  input wire logic          i_scl,
  input wire logic          i_bias_gen_en,
  input wire logic          o_sda,
  input wire logic          o_sda_oe_n,
  input wire egc_gain_cfg_s o_gain_cfg,
  input wire egc_bias_cfg_s o_bias_cfg
);
  default clocking cb @(posedge i_core_clk); endclocking

  function automatic logic [19:0] gv(egc_exp_mode_e m, logic [5:0] g);
    if (m == EGC_EXP_LINEAR2) return EGC_LIN2_BASE + EGC_LIN2_STEP * g;
    if (m == EGC_EXP_LINEAR) return EGC_LIN_BASE + EGC_COARSE_STEP * g;
    if (g <= EGC_RAW_KNEE) return EGC_RAW_BASE + EGC_RAW_FINE * g;
    return EGC_RAW_KNEE_VAL + EGC_COARSE_STEP * (g - EGC_RAW_KNEE);
  endfunction

  // Values lag reset release by one edge, hence the past reset guard
  property p_val_first;
    disable iff (!i_resetn) $past(i_resetn) |->
      o_gain_cfg.gain_first_val == gv(o_gain_cfg.exp_mode,
                                      o_gain_cfg.gain_word_first);
  endproperty
  a_val_first: assert property (p_val_first)
    else $error("first gain value wrong");
  property p_val_second;
    disable iff (!i_resetn) $past(i_resetn) && o_gain_cfg.second_used |->
      o_gain_cfg.gain_second_val == gv(o_gain_cfg.exp_mode,
                                       o_gain_cfg.gain_word_second);
  endproperty
  a_val_second: assert property (p_val_second)
    else $error("second gain value wrong");
  property p_both_used;
    disable iff (!i_resetn) $past(i_resetn) &&
      o_gain_cfg.exp_mode != EGC_EXP_LINEAR2 |-> o_gain_cfg.second_used;
  endproperty
  a_both_used: assert property (p_both_used)
    else $error("second word dropped");
  property p_lin2_only_first;
    disable iff (!i_resetn) o_gain_cfg.exp_mode == EGC_EXP_LINEAR2 |->
      !o_gain_cfg.second_used && o_gain_cfg.gain_word_second == 6'h00 &&
      o_gain_cfg.gain_second_val == 20'h00000;
  endproperty
  a_lin2_only_first: assert property (p_lin2_only_first)
    else $error("second word used in linear2");
  property p_mode_legal;
    disable iff (!i_resetn) o_gain_cfg.exp_mode inside
      {EGC_EXP_RAW, EGC_EXP_LINEAR, EGC_EXP_LINEAR2};
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("illegal exposure mode");
  property p_frc;
    disable iff (!i_resetn)
      o_bias_cfg.frc_half_current == o_bias_cfg.bias_bits[EGC_FCP_BIT];
  endproperty
  a_frc: assert property (p_frc)
    else $error("clamp current bit mismatch");
  property p_bias_off;
    disable iff (!i_resetn) !$past(i_bias_gen_en) |-> o_bias_cfg == 8'h00;
  endproperty
  a_bias_off: assert property (p_bias_off)
    else $error("bias applied while disabled");
  // Second edge in reset; every flop resets asynchronously, so the outputs are already clear by then
  property p_reset_idle;
    !i_resetn ##1 !i_resetn |->
      o_sda_oe_n && o_gain_cfg == '0 && o_bias_cfg == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs active in reset");
  // Ack must only start in the clock low phase and hold low for the next 8 core clocks
  property p_ack_hold;
    disable iff (!i_resetn) $fell(o_sda_oe_n) |-> !i_scl ##1
      (!o_sda_oe_n && o_sda == 1'b0) [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack not held");

  c_lin2: cover property (o_gain_cfg.exp_mode == EGC_EXP_LINEAR2);
  c_half: cover property (o_bias_cfg.frc_half_current);
  c_ack: cover property ($fell(o_sda_oe_n));
endmodule

bind egc_regs egc_regs_props u_egc_regs_props (
  .i_core_clk    (i_core_clk),
  .i_resetn      (i_resetn),
  .i_scl         (i_scl),
  .i_bias_gen_en (i_bias_gen_en),
  .o_sda         (o_sda),
  .o_sda_oe_n    (o_sda_oe_n),
  .o_gain_cfg    (o_gain_cfg),
  .o_bias_cfg    (o_bias_cfg)
);

// file: tb/egc_regs_bench.sv
// Self-checking bench for the gain configuration register bank
`timescale 1ns/1ps
module egc_regs_bench;
  import egc_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;
  localparam egc_gain_cfg_s RST_CFG = {6'h0e, 6'h0e, 1'b1, 20'h1869c,
                                       20'h1869c, EGC_EXP_RAW, EGC_WB_RAW};
  logic          clk         = 1'b0;
  logic          resetn      = 1'b0;
  logic          scl         = 1'b1;
  logic          tb_sda      = 1'b1;
  logic          bias_en     = 1'b0;
  logic          sda_w;
  logic          o_sda;
  logic          oe_n;
  logic [7:0]    q;
  logic          a;
  egc_gain_cfg_s gcfg;
  egc_bias_cfg_s bcfg;
  int            miscompares = 0;
  int            n_tests     = 0;
  int            cycles      = 0;
  // Offset, data written, value read back
  logic [23:0]   rows [7]    = '{24'h10ff3f, 24'h21c505, 24'h22fd05,
                                 24'h13ff7f, 24'h130101, 24'h220000,
                                 24'h50aa00};

  always #25 clk = ~clk;
  // Pull-up wire: low when the device enables its driver
  assign sda_w = tb_sda & (oe_n | o_sda);

  egc_regs #(.DEV_ADDR(DEV)) u_egc_regs (
    .i_core_clk    (clk),
    .i_resetn      (resetn),
    .i_scl         (scl),
    .i_sda         (sda_w),
    .o_sda         (o_sda),
    .o_sda_oe_n    (oe_n),
    .i_bias_gen_en (bias_en),
    .o_gain_cfg    (gcfg),
    .o_bias_cfg    (bcfg)
  );

  task automatic wrap_up();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Half period of the serial clock, long enough for the pin filters
  task automatic hc();
    repeat (12) @(negedge clk);
  endtask

  task automatic start();
    tb_sda = 1'b1;
    hc();
    scl = 1'b1;
    hc();
    tb_sda = 1'b0;
    hc();
    scl = 1'b0;
  endtask

  task automatic stop();
    tb_sda = 1'b0;
    hc();
    scl = 1'b1;
    hc();
    tb_sda = 1'b1;
    hc();
  endtask

  // Eight data bits then the ack bit; 8'hff with 1 reads and nacks
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r,
                         output logic ack);
    logic [8:0] s;
    logic [8:0] g;
    s = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      tb_sda = s[i];
      hc();
      scl = 1'b1;
      hc();
      g[i] = sda_w;
      scl = 1'b0;
    end
    r = g[8:1];
    ack = !g[0];
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
    logic [2:0] k;
    start();
    byte_io({DEV, 1'b0}, q, k[2]);
    byte_io(ofs, q, k[1]);
    byte_io(dat, q, k[0]);
    stop();
    chk(k, 3'h7);
  endtask

  task automatic rd(input logic [7:0] ofs, output logic [7:0] r);
    logic [3:0] k;
    start();
    byte_io({DEV, 1'b0}, r, k[3]);
    byte_io(ofs, r, k[2]);
    start();
    byte_io({DEV, 1'b1}, r, k[1]);
    byte_io(8'hff, r, k[0]);
    stop();
    chk(k, 4'he);
  endtask

  initial begin
    repeat (6) @(negedge clk);
    chk({gcfg, bcfg, oe_n}, 72'h1);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    chk(gcfg, RST_CFG);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], q);
      chk(q, rows[i][7:0]);
    end
    chk(bcfg, 8'h00);
    bias_en = 1'b1;
    repeat (2) @(negedge clk);
    chk(bcfg, 8'h03);
    chk(gcfg, {6'h3f, 6'h05, 1'b1, 20'h42ce8, 20'h13a2e, EGC_EXP_RAW,
               EGC_WB_RAW});
    for (int m = 0; m < 8; m++) begin
      wr(EGC_OFS_GAIN_MODE, 8'(m));
      chk({gcfg.exp_mode, gcfg.wb_mode, gcfg.second_used,
           gcfg.gain_word_second},
          {m[1] ? EGC_EXP_LINEAR2 : (m[0] ? EGC_EXP_LINEAR : EGC_EXP_RAW),
           m[2], !m[1], m[1] ? 6'h00 : 6'h05});
    end
    chk(gcfg.gain_first_val, 20'hc4630);
    wr(EGC_OFS_GAIN_MODE, 8'h00);
    wr(EGC_OFS_GAIN_A, 8'h20);
    chk(gcfg.gain_first_val, 20'h21f78);
    // Foreign address must be left unanswered
    start();
    byte_io({DEV ^ 7'h01, 1'b0}, q, a);
    stop();
    chk(a, 1'b0);
    wr(EGC_OFS_BIAS_PWR, 8'h00);
    chk(bcfg, 8'h00);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk({gcfg, bcfg, oe_n}, 72'h1);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    chk(gcfg, RST_CFG);
    wrap_up();
  end
endmodule
